/* File: rtl/sarrd_pkg.sv */
// shared constants and carrier types for the converter readout block
package sarrd_pkg;
    localparam int unsigned CLOCK_HZ = 10_000_000;
    localparam int unsigned CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
    // conversion time in ns and its cycle count, rounded down, at least one
    localparam int unsigned CONV_TIME_NS = 650;
    localparam int unsigned CONV_CYCLES_RAW = CONV_TIME_NS / CLOCK_PERIOD_NS;
    localparam int unsigned CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int unsigned CONV_CNT_W = 4;
    // host-side least times, kept for reference only; the bench does not use them
    localparam int unsigned START_LOW_NS = 20;
    localparam int unsigned QUIET_BEFORE_NS = 50;
    localparam int unsigned QUIET_AFTER_NS = 40;
    // trim conversions after power-on
    localparam int unsigned TRIM_CONVS = 3;
    localparam int unsigned TRIM_CNT_W = 2;
    localparam int unsigned RESULT_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [RESULT_W-1:0] LATCH_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] FILL_ONES = 8'hff;
    // one finished conversion: code plus trim-phase marker
    typedef struct packed {
        logic trimPhase;
        logic [RESULT_W-1:0] code;
    } sarrd_result_type;
    localparam int unsigned RESULT_BITS = RESULT_W + 1;
    typedef enum logic [1:0] {
        SAMPLE,
        CONVERT
    } sarrd_state_type;
endpackage : sarrd_pkg

/* File: rtl/sarrd_fifo.sv */
// parameterised valid/ready FIFO
`timescale 1ns/1ns
module sarrd_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;
    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    // storage has no reset; only pointers and count carry reset state
    always_ff @(posedge clock)
    begin
        if (doWrite)
        begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (doRead)
                rdPtr_r <= rdPtr_r + 1'b1;
            if (doWrite && !doRead)
                count_r <= count_r + 1'b1;
            else if (doRead && !doWrite)
                count_r <= count_r - 1'b1;
        end
    end
endmodule : sarrd_fifo

/* File: rtl/sarrd_core.sv */
// conversion control and parallel readout of the sampling converter
//
// Behaviour
// - falling conversion_start_n with select low switches sample to hold
// - busy rises after start falls, stays high, falls when done
// - conversion timed internally, about 650 ns, no host clock
// - sampling restarts at busy fall, whatever the select level
// - output_bus driven only when select and read both low
// - result codes are two's complement style, midscale zero
// - half-word select low: full 16-bit result, msb on top lane
// - half-word select high: low byte on upper lanes, ones below
// - reads work with toggled or continuously low read strobe
// - first three conversions after power-up load trim, invalid
// - start fall with select low during conversion resets device
// - select fall during conversion resets device
// - reset clears output latch, drops busy, sampling restarts
`timescale 1ns/1ns
module sarrd_core (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic conversion_start_n,
    input wire logic chipSelect_n,
    input wire logic readStrobe_n,
    input wire logic halfWordSel,
    input wire logic [sarrd_pkg::RESULT_W-1:0] analogCode,
    output logic busy,
    output logic holding,
    output logic [sarrd_pkg::RESULT_W-1:0] output_bus_o,
    output logic [sarrd_pkg::RESULT_W-1:0] output_bus_oe,
    output logic resultTrim,
    output logic [sarrd_pkg::RESULT_W-1:0] streamCode,
    output logic streamTrim,
    output logic streamValid,
    input wire logic streamReady,
    output logic selfReset
);
    // previous input levels for edge detection
    logic startPrev_r;
    logic selPrev_r;
    sarrd_pkg::sarrd_state_type state_r;
    sarrd_pkg::sarrd_state_type state_nxt;
    logic [sarrd_pkg::CONV_CNT_W-1:0] convCnt_r;
    logic [sarrd_pkg::CONV_CNT_W-1:0] convCnt_nxt;
    logic [sarrd_pkg::RESULT_W-1:0] heldCode_r;
    logic [sarrd_pkg::RESULT_W-1:0] result_bits_r;
    logic resultTrim_r;
    logic [sarrd_pkg::TRIM_CNT_W-1:0] trimCnt_r;
    logic busy_r;
    logic holding_r;
    logic selfReset_r;
    logic [sarrd_pkg::RESULT_W-1:0] busO_r;
    logic [sarrd_pkg::RESULT_W-1:0] busOe_r;
    sarrd_pkg::sarrd_result_type fifoIn;
    sarrd_pkg::sarrd_result_type fifoOut;
    logic fifoInReady;
    logic fifoOutValid;

    // edge decode of the host strobes
    wire startFall = startPrev_r && !conversion_start_n;
    wire selFall = selPrev_r && !chipSelect_n;
    wire converting = (state_r == sarrd_pkg::CONVERT);
    wire convStart = startFall && !chipSelect_n && !converting;
    wire abortStart = startFall && !chipSelect_n && converting;
    wire abortSel = selFall && converting;
    wire abortAny = abortStart || abortSel;
    wire convLast = converting && (convCnt_r == 
        sarrd_pkg::CONV_CNT_W'(sarrd_pkg::CONV_CYCLES - 1));
    // a full FIFO stalls completion so no finished result is ever dropped
    wire convDone = convLast && fifoInReady && !abortAny;
    wire inTrim = (trimCnt_r != sarrd_pkg::TRIM_CNT_W'(sarrd_pkg::TRIM_CONVS));

    // readout lane selection
    wire readEnable = !chipSelect_n && !readStrobe_n;
    wire [sarrd_pkg::BYTE_W-1:0] hiByte = result_bits_r[15:8];
    wire [sarrd_pkg::BYTE_W-1:0] loByte = result_bits_r[7:0];
    wire [sarrd_pkg::RESULT_W-1:0] laneData = halfWordSel ?
        {loByte, sarrd_pkg::FILL_ONES} :
        {hiByte, loByte};
    wire [sarrd_pkg::RESULT_W-1:0] laneOe = readEnable ? 16'hffff : 16'h0000;

    // conversion sequencer; internal clock counts the 650 ns window rounded down to 6 cycles
    always_comb
    begin
        state_nxt = state_r;
        convCnt_nxt = convCnt_r;
        unique case (state_r)
            sarrd_pkg::SAMPLE:
            begin
                if (convStart)
                begin
                    state_nxt = sarrd_pkg::CONVERT;
                    convCnt_nxt = '0;
                end
            end
            sarrd_pkg::CONVERT:
            begin
                if (abortAny || convDone)
                    state_nxt = sarrd_pkg::SAMPLE;
                else if (!convLast)
                    convCnt_nxt = convCnt_r + 1'b1;
            end
            default:
            begin
                state_nxt = sarrd_pkg::SAMPLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r <= sarrd_pkg::SAMPLE;
            convCnt_r <= '0;
            startPrev_r <= 1'b1;
            selPrev_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            convCnt_r <= convCnt_nxt;
            startPrev_r <= conversion_start_n;
            selPrev_r <= chipSelect_n;
        end
    end

    // sample/hold: input captured at the start edge, held until busy drops
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            heldCode_r <= '0;
            holding_r <= 1'b0;
        end
        else
        begin
            if (convStart)
                heldCode_r <= analogCode;
            holding_r <= (state_nxt == sarrd_pkg::CONVERT);
        end
    end

    // output latch and trim counter
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            result_bits_r <= sarrd_pkg::LATCH_RESET;
            resultTrim_r <= 1'b1;
            trimCnt_r <= '0;
        end
        else if (abortAny)
        begin
            result_bits_r <= sarrd_pkg::LATCH_RESET;
        end
        else if (convDone)
        begin
            result_bits_r <= heldCode_r;
            resultTrim_r <= inTrim;
            if (inTrim)
                trimCnt_r <= trimCnt_r + 1'b1;
        end
    end

    // registered pins: busy, bus drive and self-reset pulse
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            busy_r <= 1'b0;
            busO_r <= '0;
            busOe_r <= '0;
            selfReset_r <= 1'b0;
        end
        else
        begin
            busy_r <= (state_nxt == sarrd_pkg::CONVERT);
            busO_r <= laneData;
            busOe_r <= laneOe;
            selfReset_r <= abortAny;
        end
    end

    assign fifoIn.trimPhase = inTrim;
    assign fifoIn.code = heldCode_r;

    // every completed result also leaves as a stream with back-pressure
    sarrd_fifo #(
        .WIDTH(sarrd_pkg::RESULT_BITS),
        .DEPTH(sarrd_pkg::FIFO_DEPTH)
    ) resultFifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .inData(fifoIn),
        .inValid(convDone),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(fifoOutValid),
        .outReady(streamReady)
    );

    assign busy = busy_r;
    assign holding = holding_r;
    assign output_bus_o = busO_r;
    assign output_bus_oe = busOe_r;
    assign resultTrim = resultTrim_r;
    assign selfReset = selfReset_r;
    assign streamCode = fifoOut.code;
    assign streamTrim = fifoOut.trimPhase;
    assign streamValid = fifoOutValid;

    // busy must rise on the edge after a valid start
    busy_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
        convStart |=> busy)
        else $error("busy did not rise after start");

    // a started conversion is over once the counted window has passed, unless aborted or held by a full FIFO
    conv_length_a: assert property (@(posedge clock) disable iff (sys_rst)
        (convStart && fifoInReady) ##1 (!abortAny && fifoInReady) [*6]
        |=> !busy || abortAny)
        else $error("conversion length wrong");

    // start fall while converting drops busy
    start_abort_a: assert property (@(posedge clock) disable iff (sys_rst)
        abortStart |=> !busy && result_bits_r == 16'h0000)
        else $error("start abort did not reset");

    // select fall while converting drops busy and clears latch
    sel_abort_a: assert property (@(posedge clock) disable iff (sys_rst)
        abortSel |=> !busy && selfReset && result_bits_r == 16'h0000)
        else $error("select abort did not reset");

    // bus is driven only while selected and read
    bus_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
        output_bus_oe != 16'h0000 |-> $past(readEnable))
        else $error("bus driven without select and read");

    // byte mode puts low byte on top lanes and ones below
    byte_lane_a: assert property (@(posedge clock) disable iff (sys_rst)
        (halfWordSel && !abortAny && !convDone) |=>
        output_bus_o == {$past(result_bits_r[7:0]), 8'hff})
        else $error("byte mode lanes wrong");

    // word mode gives the full latch
    word_lane_a: assert property (@(posedge clock) disable iff (sys_rst)
        !halfWordSel |=> output_bus_o == $past(result_bits_r))
        else $error("word mode lanes wrong");

    // latch is stable when nothing completes or aborts
    latch_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!convDone && !abortAny) |=> $stable(result_bits_r))
        else $error("latch changed without cause");

    // trim flag clears only after three conversions
    trim_count_a: assert property (@(posedge clock) disable iff (sys_rst)
        !resultTrim |-> trimCnt_r == 2'd3)
        else $error("trim flag cleared early");
endmodule : sarrd_core

/* File: testbench/sarrd_host.sv */
// host-side partner model driving the converter control strobes
`timescale 1ns/1ns
module sarrd_host (
    input wire logic clock,
    output logic startN = 1'b1,
    output logic csN = 1'b1,
    output logic rdN = 1'b1,
    output logic hws = 1'b0,
    output logic [15:0] code = 16'h0000
);
    // strobes change together just after an edge, never on the opposite edge
    task automatic setLines(input logic c, input logic r, input logic h);
        @(posedge clock);
        csN <= c;
        rdN <= r;
        hws <= h;
    endtask : setLines
    // start held low one full cycle; read stays idle around it as the quiet zone
    task automatic startPulse(input logic [15:0] c, input logic cs);
        setLines(cs, 1'b1, 1'b0);
        code <= c;
        @(posedge clock);
        startN <= 1'b0;
        @(posedge clock);
        startN <= 1'b1;
    endtask : startPulse
endmodule : sarrd_host

/* File: testbench/tb_sar_adc_parallel_readout.sv */
// self-checking bench for the converter readout block
`timescale 1ns/1ns
module tb_sar_adc_parallel_readout;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic streamReady = 1'b1;
    logic startN, csN, rdN, hws, busy, holding, resultTrim, sTrim, sValid, selfReset;
    logic [15:0] code, busO, busOe, sCode;
    logic [15:0] c;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'ha652;
    int trimLeft = 3;
    logic [16:0] q[$];
    logic [15:0] table0[4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};
    always #50 clock = ~clock;
    sarrd_host host (.clock(clock), .startN(startN), .csN(csN), .rdN(rdN), .hws(hws),
        .code(code));
    sarrd_core DUT (.clock(clock), .sys_rst(sys_rst), .conversion_start_n(startN),
        .chipSelect_n(csN), .readStrobe_n(rdN), .halfWordSel(hws), .analogCode(code),
        .busy(busy), .holding(holding), .output_bus_o(busO), .output_bus_oe(busOe),
        .resultTrim(resultTrim), .streamCode(sCode), .streamTrim(sTrim),
        .streamValid(sValid), .streamReady(streamReady), .selfReset(selfReset));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // stream sink: every pop is compared against the model queue
    always @(posedge clock)
    begin
        cycles++;
        if (sValid === 1'b1 && streamReady === 1'b1)
            check({sTrim, sCode}, q.pop_front());
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    // one read; the bus answers one cycle after select and read go low
    task automatic readCheck(input logic h, input logic [15:0] exp);
        host.setLines(1'b0, 1'b0, h);
        @(posedge clock);
        #1 check(17'(busOe), 17'h0ffff);
        check(17'(busO), 17'(exp));
    endtask : readCheck
    // full conversion with busy length, stream queue entry and trim marker modelled
    task automatic conv(input logic [15:0] v);
        host.startPulse(v, 1'b0);
        #1 check(17'({busy, holding}), 17'h3);
        repeat (5) @(posedge clock);
        #1 check(17'(busy), 17'h1);
        @(posedge clock);
        #1 check(17'({busy, holding}), 17'h0);
        q.push_back({trimLeft > 0, v});
        check(17'(resultTrim), 17'(trimLeft > 0));
        if (trimLeft > 0)
            trimLeft--;
    endtask : conv
    // called in the time step of the abort edge: busy drops, selfReset pulses, latch clears
    task automatic abortCheck;
        #1 check(17'({busy, holding, selfReset}), 17'h1);
        readCheck(1'b0, 16'h0000);
    endtask : abortCheck
    initial
    begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        #1 check(17'(busy), 17'h0);
        check({resultTrim, busOe}, 17'h10000);
        // boundary codes then random codes, read whole and as the low byte in byte mode
        for (int i = 0; i < 8; i++)
        begin
            c = (i < 4) ? table0[i] : 16'($random(seed));
            conv(c);
            readCheck(1'b0, c);
            readCheck(1'b1, {c[7:0], 8'hff});
            host.setLines(1'b0, 1'b1, 1'b0);
            readCheck(1'b0, c);
            host.setLines(1'b1, 1'b0, 1'b0);
            @(posedge clock);
            #1 check(17'(busOe), 17'h0);
        end
        $display("test conversions and reads done");
        // start with select high is ignored
        host.startPulse(16'h1234, 1'b1);
        #1 check(17'(busy), 17'h0);
        // abort by select falling, then by a second start, in mid-conversion
        host.startPulse(16'h5a5a, 1'b0);
        host.setLines(1'b1, 1'b1, 1'b0);
        host.setLines(1'b0, 1'b1, 1'b0);
        @(posedge clock);
        abortCheck();
        host.startPulse(16'ha5a5, 1'b0);
        host.startPulse(16'h0f0f, 1'b0);
        #1 check(17'({busy, selfReset}), 17'h1);
        abortCheck();
        $display("test aborts done");
        // fill the buffer with the sink stalled; a full buffer holds busy
        streamReady <= 1'b0;
        for (int i = 0; i < 32; i++)
            conv(16'($random(seed)));
        c = 16'($random(seed));
        host.startPulse(c, 1'b0);
        repeat (8) @(posedge clock);
        #1 check(17'(busy), 17'h1);
        streamReady <= 1'b1;
        for (int i = 0; i < 50 && busy !== 1'b0; i++)
            @(posedge clock);
        q.push_back({1'b0, c});
        for (int i = 0; i < 64 && q.size() > 0; i++)
            @(posedge clock);
        check(17'(q.size()), 17'h0);
        $display("test buffer fill and drain done");
        report_and_stop();
    end
endmodule : tb_sar_adc_parallel_readout
